// ==== adc_seq_pkg.sv ====
package adc_seq_pkg;

  // ===========================================================
  // register bus
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] OFF_CONFIG = 8'h00;
  localparam logic [7:0] OFF_CONTROL = 8'h04;
  localparam logic [7:0] OFF_DATA = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;
  localparam logic [7:0] OFF_MASK = 8'h10;

  // ===========================================================
  // primary configuration register layout
  localparam int CFG_W = 12;
  localparam int CFG_BYPASS_BIT = 0;
  localparam int CFG_CHOP_BIT = 1;
  localparam int CFG_SEQ_BIT = 2;
  localparam int CFG_RATE_LSB = 3;
  localparam int CFG_DELAY_LSB = 5;
  localparam int CFG_CHAN_LSB = 8;
  localparam logic [11:0] CONFIG_RESET = 12'h001;

  // ===========================================================
  // control, data and status layouts
  localparam int CTL_START_BIT = 0;
  localparam int CTL_STOP_BIT = 1;
  localparam int DATA_CHAN_LSB = 16;
  localparam int ST_W = 3;
  localparam int ST_DONE_BIT = 0;
  localparam int ST_CHAN_BIT = 1;
  localparam int ST_OVR_BIT = 2;
  localparam logic [2:0] STATUS_RESET = 3'h0;
  localparam logic [2:0] MASK_RESET = 3'h0;

  // ===========================================================
  // conversion timing
  localparam int CHAN_W = 4;
  localparam int WORD_W = 7;
  localparam int RESULT_W = 13;
  localparam logic [6:0] PERIOD_LAST = 7'h7F;
  localparam logic [12:0] FULL_SCALE = 13'h1000;
  localparam logic [5:0] DELAY_PERIODS [8] = '{6'h00, 6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h20, 6'h30};

  // ===========================================================
  // sequencer states
  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_SETTLE = 2'b01,
    S_ACCUM = 2'b10
  } conv_state_t;

endpackage : adc_seq_pkg

// ==== conv_link_if.sv ====
interface conv_link_if;
  // first filter stage
  logic decimClear;
  logic [6:0] word;
  logic wordValid;
  // settle delay timer
  logic timerStart;
  logic [2:0] timerCode;
  logic timerDone;

  modport ctrl (output decimClear, timerStart, timerCode, input word, wordValid, timerDone);
  modport decim (input decimClear, output word, wordValid);
  modport timer (input timerStart, timerCode, output timerDone);
endinterface : conv_link_if

// ==== first_stage_decimator.sv ====
module first_stage_decimator
  import adc_seq_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // modulator stream
  input wire logic modBit,
  // link to sequencer
  conv_link_if.decim link
);

  logic [6:0] cnt_reg; // clock count within one word period
  logic [6:0] ones_reg; // ones seen in this word

  // ===========================================================
  // sample on even clocks, one word every period of 128 clocks
  always_ff @(posedge clk) begin
    if (srst || link.decimClear) begin
      cnt_reg <= 7'h00;
      ones_reg <= 7'h00;
      link.word <= 7'h00;
      link.wordValid <= 1'b0;
    end else begin
      cnt_reg <= cnt_reg + 7'h01;
      link.wordValid <= (cnt_reg == PERIOD_LAST); // [RL12]
      if (cnt_reg == PERIOD_LAST) begin
        link.word <= ones_reg;
        ones_reg <= 7'h00;
      end else if (!cnt_reg[0]) begin
        ones_reg <= ones_reg + {6'h00, modBit}; // [RL8]
      end
    end
  end

  a_odd_no_sample: assert property (@(posedge clk) disable iff (srst) // [RL8]
    (cnt_reg[0] && !link.decimClear && cnt_reg != PERIOD_LAST) |=> ones_reg == $past(ones_reg))
    else $error("modulator sampled on an odd clock");
  // a stop or restart clears the stage and cancels the pending word
  a_word_period: assert property (@(posedge clk) disable iff (srst || link.decimClear) // [RL12]
    $fell(link.decimClear) |-> ##128 link.wordValid)
    else $error("first stage word not after 128 clocks");

endmodule : first_stage_decimator

// ==== settle_delay_timer.sv ====
module settle_delay_timer
  import adc_seq_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // link to sequencer
  conv_link_if.timer link
);

  logic busy_reg; // counting a delay
  logic [5:0] periods_reg; // periods left
  logic [6:0] sub_reg; // clocks left in this period
  logic [13:0] elapsed_reg; // clocks since the last load, for checks
  logic [2:0] loadCode_reg; // code taken at the last load, for checks

  // ===========================================================
  // whole periods of 128 clocks from the code table
  always_ff @(posedge clk) begin
    if (srst) begin
      busy_reg <= 1'b0;
      periods_reg <= 6'h00;
      sub_reg <= 7'h00;
      link.timerDone <= 1'b0;
    end else if (link.timerStart) begin
      periods_reg <= DELAY_PERIODS[link.timerCode]; // [RL5]
      sub_reg <= PERIOD_LAST; // [RL6]
      busy_reg <= (DELAY_PERIODS[link.timerCode] != 6'h00);
      link.timerDone <= (DELAY_PERIODS[link.timerCode] == 6'h00);
    end else if (busy_reg) begin
      link.timerDone <= 1'b0;
      if (sub_reg != 7'h00) begin
        sub_reg <= sub_reg - 7'h01;
      end else if (periods_reg == 6'h01) begin
        busy_reg <= 1'b0;
        link.timerDone <= 1'b1;
      end else begin
        periods_reg <= periods_reg - 6'h01;
        sub_reg <= PERIOD_LAST;
      end
    end else begin
      link.timerDone <= 1'b0;
    end
  end

  // ===========================================================
  // check helper: clocks since the last load, saturating; a reload restarts the reckoning
  always_ff @(posedge clk) begin
    if (srst) begin
      elapsed_reg <= 14'h3FFF;
      loadCode_reg <= 3'h0;
    end else if (link.timerStart) begin
      elapsed_reg <= 14'h0000;
      loadCode_reg <= link.timerCode;
    end else if (elapsed_reg != 14'h3FFF) begin
      elapsed_reg <= elapsed_reg + 14'h0001;
    end
  end

  a_delay_zero: assert property (@(posedge clk) disable iff (srst) // [RL5]
    (link.timerStart && link.timerCode == 3'h0) |=> link.timerDone)
    else $error("zero delay not immediate");
  a_delay_two: assert property (@(posedge clk) disable iff (srst) // [RL5]
    (loadCode_reg == 3'h2 && elapsed_reg != 14'h3FFF) |-> link.timerDone == (elapsed_reg == 14'h0100))
    else $error("two period delay wrong length");
  a_delay_rate: assert property (@(posedge clk) disable iff (srst) // [RL6]
    (loadCode_reg == 3'h1 && elapsed_reg != 14'h3FFF) |-> link.timerDone == (elapsed_reg == 14'h0080))
    else $error("delay period not 128 clocks");

endmodule : settle_delay_timer

// ==== adc_conversion_timing_control.sv ====
// Overview of operation
// RL1: sequencing mode: flag low per channel result
// RL2: start with steady input gives settled first result
// RL3: host holds input one cycle before trusting
// RL4: fastest single-input rate needs five steady cycles
// RL5: delay codes insert 0..48 periods of 128
// RL6: delay and rates derive from master clock
// RL7: polarity swap halves the result rate
// RL8: modulator sampled at half master clock
// RL9: bypass bit clear selects internal routing
// RL10: multiplexer outputs driven regardless of bypass
// RL11: host programs delay for slow external buffers
// RL12: first stage decimates 64, word per 128
// RL13: second stage averages 1, 4, 16, 64
// RL14: settle delay after each multiplexer change
//
// Implementation choices: the register addresses and the strobed register port.
module adc_conversion_timing_control
  import adc_seq_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // register port
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdata,
  // conversion control and modulator stream
  input wire logic startPin,
  input wire logic modBit,
  // converter side outputs
  output logic conversionDoneFlagN,
  output logic [3:0] muxSel,
  output logic muxOutEnable,
  output logic internalBypass,
  output logic polaritySwap,
  // interrupt
  output logic irq
);

  // ===========================================================
  // declarations
  conv_link_if link ();

  logic [11:0] config_reg; // primary configuration register
  logic [2:0] status_reg; // sticky events
  logic [2:0] mask_reg; // interrupt enables
  logic running_reg; // conversions requested
  logic startPrev_reg; // start pin one clock ago
  conv_state_t state_reg; // sequencer state
  logic chopPhase_reg; // second reading of a swapped pair
  logic [12:0] acc_reg; // second stage sum
  logic [5:0] wordCnt_reg; // words taken so far
  logic [12:0] firstHalf_reg; // normalized first reading
  logic [12:0] result_reg; // published result
  logic [3:0] resultChan_reg; // channel of that result
  logic resultEvent_reg; // one clock pulse per result
  logic drdyN_reg; // done flag, low while unread
  logic [3:0] muxSel_reg; // selected channel
  logic [31:0] rdata_reg; // read data stage

  logic bypassBit; // config fields
  logic chopEn;
  logic seqMode;
  logic [1:0] rateSel;
  logic [2:0] delaySel;
  logic [3:0] fixedChan;
  logic wrConfig; // register strobes
  logic wrControl;
  logic wrStatus;
  logic wrMask;
  logic rdData;
  logic startEvent; // start request from pin or command
  logic stopEvent; // stop request from pin or command
  logic enterSettle; // sequencer enters settle this clock
  logic lastWord; // current word closes the average
  logic finishPair; // closing word of a full result
  logic [5:0] lastIndex; // words per average minus one
  logic [12:0] accNext; // sum including current word
  logic [12:0] normSum; // sum scaled to full scale
  logic [13:0] pairSum; // both halves of a swapped pair
  logic [12:0] resultNext; // value to publish

  // ===========================================================
  // submodules
  first_stage_decimator u_decim (
    .clk(clk),
    .srst(srst),
    .modBit(modBit),
    .link(link.decim)
  );

  settle_delay_timer u_timer (
    .clk(clk),
    .srst(srst),
    .link(link.timer)
  );

  // ===========================================================
  // field decode
  assign bypassBit = config_reg[CFG_BYPASS_BIT];
  assign chopEn = config_reg[CFG_CHOP_BIT];
  assign seqMode = config_reg[CFG_SEQ_BIT];
  assign rateSel = config_reg[CFG_RATE_LSB +: 2];
  assign delaySel = config_reg[CFG_DELAY_LSB +: 3];
  assign fixedChan = config_reg[CFG_CHAN_LSB +: CHAN_W];

  // strobe decode
  assign wrConfig = regWrite && (regAddr == OFF_CONFIG);
  assign wrControl = regWrite && (regAddr == OFF_CONTROL);
  assign wrStatus = regWrite && (regAddr == OFF_STATUS);
  assign wrMask = regWrite && (regAddr == OFF_MASK);
  assign rdData = regRead && (regAddr == OFF_DATA);

  // start on pin rising edge or command, stop on falling edge or command
  assign startEvent = (startPin && !startPrev_reg) || (wrControl && regWdata[CTL_START_BIT]);
  assign stopEvent = (!startPin && startPrev_reg) || (wrControl && regWdata[CTL_STOP_BIT]);

  // ===========================================================
  // second stage arithmetic
  always_comb begin
    unique case (rateSel)
      2'b11: lastIndex = 6'h00; // [RL13]
      2'b10: lastIndex = 6'h03;
      2'b01: lastIndex = 6'h0F;
      2'b00: lastIndex = 6'h3F;
    endcase
  end

  assign accNext = acc_reg + {6'h00, link.word};
  assign normSum = accNext << {rateSel, 1'b0};
  assign pairSum = {1'b0, firstHalf_reg} + {1'b0, FULL_SCALE - normSum};
  assign resultNext = chopEn ? pairSum[13:1] : normSum;
  assign lastWord = (state_reg == S_ACCUM) && link.wordValid && (wordCnt_reg == lastIndex);
  assign finishPair = lastWord && !startEvent && !stopEvent && (!chopEn || chopPhase_reg);

  // settle entered from idle, on restart, between halves or after a result
  assign enterSettle = ((state_reg == S_IDLE) && startEvent)
    || ((state_reg != S_IDLE) && startEvent && !stopEvent)
    || (lastWord && !stopEvent);

  // ===========================================================
  // links to submodules
  assign link.decimClear = (state_reg != S_ACCUM); // [RL2]
  assign link.timerStart = enterSettle; // [RL14]
  assign link.timerCode = (seqMode || chopEn) ? delaySel : 3'h0; // [RL14]

  // ===========================================================
  // configuration and mask registers
  always_ff @(posedge clk) begin
    if (srst) begin
      config_reg <= CONFIG_RESET;
    end else if (wrConfig) begin
      config_reg <= regWdata[CFG_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      mask_reg <= MASK_RESET;
    end else if (wrMask) begin
      mask_reg <= regWdata[ST_W-1:0];
    end
  end

  // ===========================================================
  // run request and start pin history
  always_ff @(posedge clk) begin
    if (srst) begin
      running_reg <= 1'b0;
      startPrev_reg <= 1'b0;
    end else begin
      startPrev_reg <= startPin;
      if (stopEvent) begin
        running_reg <= 1'b0;
      end else if (startEvent) begin
        running_reg <= 1'b1;
      end
    end
  end

  // ===========================================================
  // sequencer: settle, accumulate, publish
  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= S_IDLE;
      chopPhase_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        S_IDLE: begin
          if (startEvent) begin
            state_reg <= S_SETTLE; // [RL2]
            chopPhase_reg <= 1'b0;
          end
        end
        S_SETTLE: begin
          if (stopEvent) begin
            state_reg <= S_IDLE;
          end else if (startEvent) begin
            chopPhase_reg <= 1'b0;
          end else if (link.timerDone) begin
            state_reg <= S_ACCUM;
          end
        end
        S_ACCUM: begin
          if (stopEvent) begin
            state_reg <= S_IDLE;
          end else if (startEvent) begin
            state_reg <= S_SETTLE; // fresh start discards partial sums
            chopPhase_reg <= 1'b0;
          end else if (lastWord) begin
            state_reg <= S_SETTLE; // [RL14]
            chopPhase_reg <= chopEn && !chopPhase_reg; // [RL7]
          end
        end
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end

  // averager sums words while accumulating
  always_ff @(posedge clk) begin
    if (srst) begin
      acc_reg <= 13'h0000;
      wordCnt_reg <= 6'h00;
    end else if (state_reg != S_ACCUM || lastWord) begin
      acc_reg <= 13'h0000;
      wordCnt_reg <= 6'h00;
    end else if (link.wordValid) begin
      acc_reg <= accNext; // [RL13]
      wordCnt_reg <= wordCnt_reg + 6'h01;
    end
  end

  // first half of a swapped pair is held for the average
  always_ff @(posedge clk) begin
    if (srst) begin
      firstHalf_reg <= 13'h0000;
    end else if (lastWord && chopEn && !chopPhase_reg) begin
      firstHalf_reg <= normSum; // [RL7]
    end
  end

  // ===========================================================
  // result publication and done flag
  always_ff @(posedge clk) begin
    if (srst) begin
      result_reg <= 13'h0000;
      resultChan_reg <= 4'h0;
      resultEvent_reg <= 1'b0;
    end else begin
      resultEvent_reg <= finishPair;
      if (finishPair) begin
        result_reg <= resultNext;
        resultChan_reg <= muxSel_reg;
      end
    end
  end

  // flag falls on each result and rises on the data read; result wins
  always_ff @(posedge clk) begin
    if (srst) begin
      drdyN_reg <= 1'b1;
    end else if (finishPair) begin
      drdyN_reg <= 1'b0; // [RL1]
    end else if (rdData) begin
      drdyN_reg <= 1'b1;
    end
  end

  // ===========================================================
  // channel select: fixed channel or stepping sequence
  always_ff @(posedge clk) begin
    if (srst) begin
      muxSel_reg <= 4'h0;
    end else if (startEvent || !seqMode) begin
      muxSel_reg <= fixedChan;
    end else if (finishPair) begin
      muxSel_reg <= muxSel_reg + 4'h1; // [RL14]
    end
  end

  // ===========================================================
  // sticky status, write one to clear, set wins
  always_ff @(posedge clk) begin
    if (srst) begin
      status_reg <= STATUS_RESET;
    end else begin
      for (int i = 0; i < ST_W; i++) begin
        if (wrStatus && regWdata[i]) begin
          status_reg[i] <= 1'b0;
        end
      end
      if (finishPair) begin
        status_reg[ST_DONE_BIT] <= 1'b1;
      end
      if (finishPair && seqMode) begin
        status_reg[ST_CHAN_BIT] <= 1'b1;
      end
      if (finishPair && !drdyN_reg && !rdData) begin
        status_reg[ST_OVR_BIT] <= 1'b1;
      end
    end
  end

  // ===========================================================
  // register read, data one clock after the strobe
  always_ff @(posedge clk) begin
    if (srst) begin
      rdata_reg <= 32'h0000_0000;
    end else if (regRead) begin
      unique case (regAddr)
        OFF_CONFIG: rdata_reg <= {20'h00000, config_reg};
        OFF_CONTROL: rdata_reg <= {31'h0000_0000, running_reg};
        OFF_DATA: rdata_reg <= {12'h000, resultChan_reg, 3'h0, result_reg};
        OFF_STATUS: rdata_reg <= {29'h0000_0000, status_reg};
        OFF_MASK: rdata_reg <= {29'h0000_0000, mask_reg};
        default: rdata_reg <= 32'h0000_0000; // unmapped reads zero
      endcase
    end else begin
      rdata_reg <= 32'h0000_0000;
    end
  end

  // ===========================================================
  // outputs
  assign regRdata = rdata_reg;
  assign conversionDoneFlagN = drdyN_reg;
  assign muxSel = muxSel_reg;
  assign muxOutEnable = 1'b1; // [RL10]
  assign internalBypass = !bypassBit; // [RL9]
  assign polaritySwap = chopPhase_reg;
  assign irq = |(status_reg & mask_reg);

  // ===========================================================
  // checks
  a_flag_on_result: assert property (@(posedge clk) disable iff (srst) // [RL1]
    resultEvent_reg |-> !conversionDoneFlagN)
    else $error("done flag not low with result");
  a_start_fresh: assert property (@(posedge clk) disable iff (srst) // [RL2]
    (state_reg == S_IDLE && startEvent) |=> state_reg == S_SETTLE && link.decimClear && acc_reg == 13'h0000)
    else $error("start does not restart the filter");
  a_bypass_route: assert property (@(posedge clk) disable iff (srst) // [RL9]
    (wrConfig && !regWdata[CFG_BYPASS_BIT]) |=> internalBypass)
    else $error("internal bypass not selected");
  a_mux_driven: assert property (@(posedge clk) disable iff (srst) // [RL10]
    muxOutEnable)
    else $error("multiplexer outputs released");
  a_single_avg: assert property (@(posedge clk) disable iff (srst) // [RL13]
    (state_reg == S_ACCUM && link.wordValid && rateSel == 2'b11 && !chopEn && !startEvent && !stopEvent)
      |=> resultEvent_reg)
    else $error("single average result missing");
  a_swap_half: assert property (@(posedge clk) disable iff (srst) // [RL7]
    (lastWord && chopEn && !chopPhase_reg && !startEvent && !stopEvent)
      |=> !resultEvent_reg && polaritySwap && state_reg == S_SETTLE)
    else $error("swapped pair published early");
  a_settle_after_step: assert property (@(posedge clk) disable iff (srst) // [RL14]
    (seqMode && !$changed(config_reg) && $changed(muxSel_reg) && !$past(startEvent))
      |-> state_reg == S_SETTLE && $past(link.timerStart))
    else $error("channel change without settle delay");

endmodule : adc_conversion_timing_control

// ==== host_stim_model.sv ====
module host_stim_model (
  // clock
  input wire logic clk,
  // pins toward the converter
  output logic startPin,
  output logic modBit
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================
  // steady analog level for every conversion
  initial begin
    startPin = 1'b0;
    // level never moves, so each result sees settled input
    modBit = 1'b1;
  end

  // ==========================================
  // start pin, changed just after an edge
  task setStart(input logic v);
    @(posedge clk);
    startPin <= v; // rise starts, fall stops
  endtask : setStart
endmodule : host_stim_model

// ==== tb_top.sv ====
module tb_top
  import adc_seq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================
  // stimulus and observed signals
  logic clk;
  logic srst;
  logic [7:0] regAddr;
  logic [31:0] regWdata;
  logic regWrite;
  logic regRead;
  logic [31:0] regRdata;
  logic startPin;
  logic modBit;
  logic conversionDoneFlagN;
  logic [3:0] muxSel;
  logic muxOutEnable;
  logic internalBypass;
  logic polaritySwap;
  logic irq;
  int nFail; // mismatches
  int nTests; // comparisons
  logic [31:0] rdv; // last read word
  int n; // edges counted
  int p; // plain result spacing
  logic sw; // swap seen while waiting
  int dp [8] = '{0, 1, 2, 4, 8, 16, 32, 48}; // delay periods per code

  // ==========================================
  // design and far-side model
  adc_conversion_timing_control dut (.clk(clk), .srst(srst), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .startPin(startPin), .modBit(modBit),
    .conversionDoneFlagN(conversionDoneFlagN), .muxSel(muxSel), .muxOutEnable(muxOutEnable),
    .internalBypass(internalBypass), .polaritySwap(polaritySwap), .irq(irq));
  host_stim_model host (.clk(clk), .startPin(startPin), .modBit(modBit));

  // 25 MHz master clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ==========================================
  // bus tasks and checks
  task cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    nTests++;
    if (g !== e) begin
      nFail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task rd(input logic [7:0] a);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    #1;
    rdv = regRdata;
  endtask : rd

  // configuration word: channel, delay, rate, sequence, chop, external loop
  function automatic logic [31:0] cfg(input logic [1:0] r, input logic [2:0] k, input logic s, input logic c,
    input logic [3:0] ch);
    return {20'h0, ch, k, r, s, c, 1'b1};
  endfunction : cfg

  // count edges until the done flag drops, bounded
  task waitFlag;
    n = 0;
    sw = 1'b0;
    do begin
      @(posedge clk);
      #1;
      n++;
      sw = sw | (polaritySwap === 1'b1);
    end while (conversionDoneFlagN !== 1'b0 && n < 20000);
  endtask : waitFlag

  task go(input logic [31:0] c);
    wr(OFF_CONFIG, c);
    wr(OFF_CONTROL, 32'h1);
  endtask : go

  // stop, drain the result and clear sticky status
  task halt;
    wr(OFF_CONTROL, 32'h2);
    rd(OFF_DATA);
    wr(OFF_STATUS, 32'h7);
  endtask : halt

  // ==========================================
  // scenarios
  task t_reset;
    #1;
    cmp("flag", 1, conversionDoneFlagN);
    cmp("muxSel", 0, muxSel);
    cmp("muxOutEnable", 1, muxOutEnable);
    cmp("internalBypass", 0, internalBypass);
    cmp("irq", 0, irq);
    rd(OFF_CONFIG);
    cmp("config", {20'h0, CONFIG_RESET}, rdv);
    rd(8'h14);
    cmp("unmapped", 0, rdv);
    rd(OFF_MASK);
    cmp("mask", 0, rdv);
  endtask : t_reset

  task t_bypass;
    wr(OFF_CONFIG, 32'h0);
    @(posedge clk);
    #1;
    cmp("bypassOn", 1, internalBypass);
    cmp("muxOeBypass", 1, muxOutEnable);
    wr(OFF_CONFIG, 32'h1);
    @(posedge clk);
    #1;
    cmp("bypassOff", 0, internalBypass);
  endtask : t_bypass

  // each rate code: one word per 128 clocks, 1/4/16/64 words averaged
  task t_rates;
    for (int r = 3; r >= 0; r--) begin
      go(cfg(r[1:0], 3'h0, 1'b0, 1'b0, 4'h0));
      waitFlag();
      cmp("rateLatency", 2 + 128 * (4 ** (3 - r)), n);
      halt();
    end
  endtask : t_rates

  // each delay code in sequencing mode
  task t_delays;
    for (int k = 0; k < 8; k++) begin
      go(cfg(2'h3, k[2:0], 1'b1, 1'b0, 4'h0));
      waitFlag();
      cmp("delayLatency", 130 + dp[k] * 128, n);
      halt();
    end
  endtask : t_delays

  // sequencing from the last channel wraps to channel 0
  task t_seq;
    go(cfg(2'h3, 3'h1, 1'b1, 1'b0, 4'hF));
    waitFlag();
    rd(OFF_DATA);
    cmp("seqChanA", 4'hF, rdv[19:16]);
    cmp("flagCleared", 1, conversionDoneFlagN);
    cmp("muxWrap", 0, muxSel);
    waitFlag();
    cmp("seqGap", 256, n);
    cmp("seqFlag", 0, conversionDoneFlagN);
    rd(OFF_DATA);
    cmp("seqChanB", 4'h0, rdv[19:16]);
    halt();
  endtask : t_seq

  // swapped pair gives half the plain rate; steady input cancels to mid scale
  task t_chop;
    go(cfg(2'h3, 3'h0, 1'b0, 1'b0, 4'h0));
    waitFlag();
    rd(OFF_DATA);
    waitFlag();
    p = n + 2;
    halt();
    go(cfg(2'h3, 3'h0, 1'b0, 1'b1, 4'h0));
    waitFlag();
    rd(OFF_DATA);
    cmp("chopResult", 13'h0800, rdv[12:0]);
    waitFlag();
    cmp("chopGap", 2 * p, n + 2);
    cmp("swapSeen", 1, sw);
    halt();
  endtask : t_chop

  // level interrupt from sticky result bit, masked then cleared
  task t_irq;
    go(cfg(2'h3, 3'h0, 1'b0, 1'b0, 4'h0));
    waitFlag();
    wr(OFF_CONTROL, 32'h2);
    cmp("irqMasked", 0, irq);
    wr(OFF_MASK, 32'h1);
    @(posedge clk);
    #1;
    cmp("irqRaised", 1, irq);
    rd(OFF_STATUS);
    cmp("statusDone", 1, rdv[ST_DONE_BIT]);
    wr(OFF_STATUS, 32'h7);
    @(posedge clk);
    #1;
    cmp("irqCleared", 0, irq);
    wr(OFF_MASK, 32'h0);
    rd(OFF_DATA);
  endtask : t_irq

  // start pin rise starts, fall stops
  task t_pin;
    host.setStart(1'b1);
    waitFlag();
    cmp("pinLatency", 131, n);
    rd(OFF_DATA);
    host.setStart(1'b0);
    rd(OFF_CONTROL);
    cmp("stopped", 0, rdv[0]);
    repeat (300) @(posedge clk);
    #1;
    cmp("noResult", 1, conversionDoneFlagN);
    wr(OFF_STATUS, 32'h7);
  endtask : t_pin

  // ==========================================
  // verdict and run control
  task give_verdict;
    if (nFail == 0 && nTests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : give_verdict

  // watchdog: about twice the expected run
  initial begin
    #2400000;
    nFail++;
    give_verdict();
  end

  initial begin
    nFail = 0;
    nTests = 0;
    srst = 1'b1;
    regAddr = 8'h00;
    regWdata = 32'h0;
    regWrite = 1'b0;
    regRead = 1'b0;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    t_bypass();
    t_rates();
    t_delays();
    t_seq();
    t_chop();
    t_irq();
    t_pin();
    give_verdict();
  end
endmodule : tb_top
